/* ieb_cfg.svh */
// interrupt enable bank: register offsets, implemented-bit masks, reset values
// assumes a 32-bit classic wishbone slave, one register per aligned word
`ifndef IEB_CFG_SVH
`define IEB_CFG_SVH
`define IEB_NUM_EN        5
`define IEB_OFF_EN0       8'h00
`define IEB_OFF_EN1       8'h04
`define IEB_OFF_EN2       8'h08
`define IEB_OFF_EN3       8'h0C
`define IEB_OFF_EN4       8'h10
`define IEB_OFF_FLAG0     8'h20
`define IEB_OFF_FLAG1     8'h24
`define IEB_OFF_FLAG2     8'h28
`define IEB_OFF_FLAG3     8'h2C
`define IEB_OFF_FLAG4     8'h30
`define IEB_OFF_MASK      8'h40
`define IEB_OFF_PEND      8'h44
`define IEB_MASK_EN0      16'h7FFF
`define IEB_MASK_EN1      16'hFFFB
`define IEB_MASK_EN2      16'hDFFF
`define IEB_MASK_EN3      16'h21FF
`define IEB_MASK_EN4      16'h00F6
`define IEB_RST_EN        16'h0000
`define IEB_RST_FLAG      16'h0000
`define IEB_RST_MASK      5'h00
`define IEB_BIT_DMA1      14
`define IEB_BIT_ADC1      13
`define IEB_BIT_U1TX      12
`define IEB_BIT_U1RX      11
`define IEB_BIT_SPI1      10
`define IEB_BIT_SPI1E     9
`define IEB_BIT_TMR3      8
`define IEB_BIT_TMR2      7
`define IEB_BIT_OC2       6
`define IEB_BIT_IC2       5
`define IEB_BIT_DMA0      4
`define IEB_BIT_TMR1      3
`define IEB_BIT_OC1       2
`define IEB_BIT_IC1       1
`define IEB_BIT_EXT0      0
`endif

/* ieb_chk.sv */
// checker for the interrupt enable bank: bus timing, gating, reset, bit layout
// assumes the ports of ieb_top and the masks of ieb_cfg.svh
`timescale 1ns/100ps
`include "ieb_cfg.svh"
module ieb_chk
   import ieb_pkg::*;
#(
   parameter int NREG = 5
) (
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic                we_i,
   input wire logic [7:0]          adr_i,
   input wire logic [3:0]          sel_i,
   input wire logic [31:0]         dat_i,
   input wire logic [31:0]         dat_o,
   input wire logic                ack_o,
   input wire logic [NREG*16-1:0]  src_req_i,
   input wire logic [NREG*16-1:0]  req_o,
   input wire logic [NREG*16-1:0]  enable_o,
   input wire logic                irq_o
);
   // implemented positions of all five registers, register 0 lowest
   localparam logic [NREG*16-1:0] IMPL = {`IEB_MASK_EN4, `IEB_MASK_EN3, `IEB_MASK_EN2,
                                          `IEB_MASK_EN1, `IEB_MASK_EN0};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a request is taken only while the slave is idle
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_wr0; s_take ##0 (we_i && adr_i == `IEB_OFF_EN0 && sel_i[1:0] == 2'h3); endsequence
   property p_ack_lat; s_take |=> ack_o; endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_gate; (req_o & ~enable_o) == '0; endproperty
   a_gate: assert property (p_gate) else $error("request passed a clear enable");
   property p_impl; ((enable_o | req_o) & ~IMPL) == '0; endproperty
   a_impl: assert property (p_impl) else $error("unimplemented bit set");
   property p_en_rst; $past(rst_i) |-> enable_o == '0; endproperty
   a_en_rst: assert property (p_en_rst) else $error("enable not zero after reset");
   property p_wr0; s_wr0 |=> enable_o[15:0] == ($past(dat_i[15:0]) & `IEB_MASK_EN0); endproperty
   a_wr0: assert property (p_wr0) else $error("enable 0 write lost");
   property p_hold; !(cyc_i && stb_i && we_i && !ack_o) |=> $stable(enable_o); endproperty
   a_hold: assert property (p_hold) else $error("enable changed without write");
   property p_rd0; ack_o && !we_i && adr_i == `IEB_OFF_EN0 |-> dat_o[15:0] == enable_o[15:0];
   endproperty
   a_rd0: assert property (p_rd0) else $error("enable 0 read differs");
   // irq follows the registers combinationally, with no lag, yet two quiet cycles are required
   property p_irq_off; (enable_o == '0) [*2] |-> !irq_o; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq with all disabled");
endmodule // ieb_chk

bind ieb_top ieb_chk #(.NREG(NREG)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .src_req_i(src_req_i), .req_o(req_o), .enable_o(enable_o), .irq_o(irq_o));

/* ieb_gate.sv */
// interrupt enable bank: per-bit gating of flag by enable
// assumes flag and enable words of the same layout
`timescale 1ns/100ps
module ieb_gate #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] flag_i,
   input  wire logic [W-1:0] enable_i,
   input  wire logic [W-1:0] impl_i,
   output logic      [W-1:0] req_o
);
   genvar g;
   // one and-gate per source; unimplemented positions never request
   generate
      for (g = 0; g < W; g++) begin : g_bit
         assign req_o[g] = flag_i[g] & enable_i[g] & impl_i[g];
      end
   endgenerate
endmodule // ieb_gate

/* ieb_pkg.sv */
// interrupt enable bank: shared types
// assumes ieb_cfg.svh supplies the numeric constants
package ieb_pkg;
   typedef logic [15:0] ieb_word_t;
   typedef enum logic {IEB_IDLE, IEB_ACK} ieb_bus_state_t;
endpackage

/* ieb_top.sv */
// interrupt enable bank: five enable registers, flag registers, gated requests
// assumes classic wishbone, 32-bit data, single clock, synchronous reset
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "ieb_cfg.svh"
module ieb_top
   import ieb_pkg::*;
#(
   parameter int NREG = `IEB_NUM_EN
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   input  wire logic [NREG*16-1:0]   src_req_i,
   output logic      [NREG*16-1:0]   req_o,
   output logic      [NREG*16-1:0]   enable_o,
   output logic                      irq_o
);
   // implemented-bit masks, register 0 lowest; enable and flag share one layout,
   // so each source's bit position comes from the config header and serves both
   localparam logic [NREG*16-1:0] IMPL = {
      `IEB_MASK_EN4,
      `IEB_MASK_EN3,
      `IEB_MASK_EN2,
      `IEB_MASK_EN1,
      `IEB_MASK_EN0
   };

   ieb_word_t        en_ff   [NREG];
   ieb_word_t        nxt_en  [NREG];
   ieb_word_t        flag_ff [NREG];
   ieb_word_t        nxt_flag[NREG];
   logic [NREG-1:0]  mask_ff;
   logic [NREG-1:0]  nxt_mask;
   ieb_bus_state_t   bus_ff;
   ieb_bus_state_t   nxt_bus;
   logic [31:0]      rdat_ff;
   logic [31:0]      nxt_rdat;
   logic [NREG*16-1:0] flag_flat;
   logic [NREG*16-1:0] en_flat;
   logic [NREG-1:0]  pend;
   logic             acc;
   logic             wr;
   logic [15:0]      wdat;
   logic [15:0]      lane_m;

   // a request is taken on the first cycle of cyc&stb; ack follows one cycle later
   assign acc  = cyc_i & stb_i & (bus_ff == IEB_IDLE);
   assign wr   = acc & we_i;
   assign lane_m = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   assign wdat = dat_i[15:0];

   genvar r;
   generate
      for (r = 0; r < NREG; r++) begin : g_flat
         assign flag_flat[r*16 +: 16] = flag_ff[r];
         assign en_flat[r*16 +: 16]   = en_ff[r];
         // unlatched status per register: any gated request in that register
         assign pend[r] = |req_o[r*16 +: 16];
      end
   endgenerate

   ieb_gate #(
      .W (NREG*16)
   ) u_gate (
      .flag_i   (flag_flat),
      .enable_i (en_flat),
      .impl_i   (IMPL),
      .req_o    (req_o)
   );

   assign enable_o = en_flat;
   // level interrupt while any unmasked register has a live request
   assign irq_o    = |(pend & mask_ff);

   // register next-state: writes, flag set and write-one-to-clear
   always_comb begin
      logic [7:0] off;
      off      = 8'h00;
      nxt_mask = mask_ff;
      for (int i = 0; i < NREG; i++) begin
         nxt_en[i] = en_ff[i];
         // hardware set wins over a software clear in the same cycle
         nxt_flag[i] = (flag_ff[i] & ~(wr && adr_i == (`IEB_OFF_FLAG0 + 8'(4*i))
                        ? (wdat & lane_m) : 16'h0000))
                       | (src_req_i[i*16 +: 16] & IMPL[i*16 +: 16]);
         off = `IEB_OFF_EN0 + 8'(4*i);
         if (wr && adr_i == off) begin
            // only implemented bits take writes
            nxt_en[i] = (en_ff[i] & ~(lane_m & IMPL[i*16 +: 16]))
                        | (wdat & lane_m & IMPL[i*16 +: 16]);
         end
      end
      if (wr && adr_i == `IEB_OFF_MASK && sel_i[0]) begin
         nxt_mask = dat_i[NREG-1:0];
      end
   end

   // read mux; unmapped offsets return zero
   always_comb begin
      nxt_rdat = 32'h0000_0000;
      for (int i = 0; i < NREG; i++) begin
         if (adr_i == `IEB_OFF_EN0 + 8'(4*i)) begin
            nxt_rdat[15:0] = en_ff[i] & IMPL[i*16 +: 16];
         end
         if (adr_i == `IEB_OFF_FLAG0 + 8'(4*i)) begin
            nxt_rdat[15:0] = flag_ff[i];
         end
      end
      if (adr_i == `IEB_OFF_MASK) begin
         nxt_rdat[NREG-1:0] = mask_ff;
      end
      if (adr_i == `IEB_OFF_PEND) begin
         nxt_rdat[NREG-1:0] = pend;
      end
      if (!acc || we_i) begin
         nxt_rdat = rdat_ff;
      end
   end

   // bus handshake: ack for one cycle, then idle at least one cycle
   always_comb begin
      nxt_bus = bus_ff;
      unique case (bus_ff)
         IEB_IDLE: if (acc) nxt_bus = IEB_ACK;
         IEB_ACK:  nxt_bus = IEB_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NREG; i++) begin
            en_ff[i]   <= `IEB_RST_EN;
            flag_ff[i] <= `IEB_RST_FLAG;
         end
         mask_ff <= `IEB_RST_MASK;
         bus_ff  <= IEB_IDLE;
         rdat_ff <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < NREG; i++) begin
            en_ff[i]   <= nxt_en[i];
            flag_ff[i] <= nxt_flag[i];
         end
         mask_ff <= nxt_mask;
         bus_ff  <= nxt_bus;
         rdat_ff <= nxt_rdat;
      end
   end

   assign ack_o = (bus_ff == IEB_ACK);
   assign dat_o = rdat_ff;
endmodule // ieb_top

/* tb_interrupt_enable_bank.sv */
// testbench for the interrupt enable bank: register access, layout, gating, irq
// assumes ieb_top as a classic wishbone slave, checker bound by ieb_chk.sv
`timescale 1ns/100ps
`include "ieb_cfg.svh"
module tb_interrupt_enable_bank;
   import ieb_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [79:0] src_req_i = '0, req_o, enable_o;
   logic        ack_o, irq_o;
   int          err_total = 0, n_tests = 0, cyc_n = 0;
   logic [15:0] impl [5] = '{`IEB_MASK_EN0, `IEB_MASK_EN1, `IEB_MASK_EN2, `IEB_MASK_EN3,
                             `IEB_MASK_EN4};
   ieb_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .src_req_i(src_req_i), .req_o(req_o), .enable_o(enable_o), .irq_o(irq_o));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // the whole run needs well under a thousand cycles; a hang ends here
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         err_total = err_total + 1;
         wrap_up();
      end
   end
   task automatic check(string nm, logic [79:0] seen, logic [79:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle: request held until ack is sampled, then one idle cycle
   task automatic wb(logic w, logic [7:0] a, logic [15:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {16'h0000, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic t_regs();
      for (int r = 0; r < 5; r++) begin
         wb(1'b0, 8'(r * 4), 16'h0000);
         check("enable reset", rd[15:0], 80'h0);
         wb(1'b1, 8'(r * 4), 16'hFFFF);
         wb(1'b0, 8'(r * 4), 16'h0000);
         check("enable ones", rd[15:0], impl[r]);
         check("enable port", enable_o[r*16+:16], impl[r]);
         wb(1'b1, 8'(r * 4), 16'h0000);
      end
      wb(1'b0, 8'h80, 16'h0000);
      check("unmapped read", rd, 80'h0);
      $display("t_regs done");
   endtask
   task automatic t_gate();
      @(posedge clk_i);
      src_req_i <= '1;
      @(posedge clk_i);
      src_req_i <= '0;
      repeat (2) @(posedge clk_i);
      #1 check("req disabled", req_o, 80'h0);
      check("irq disabled", irq_o, 80'h0);
      wb(1'b1, `IEB_OFF_EN0, 16'h4010);
      repeat (2) @(posedge clk_i);
      #1 check("req enabled", req_o, 80'h4010);
      // the per-register mask leaves reset at zero, which keeps irq low
      check("irq masked", irq_o, 80'h0);
      wb(1'b1, `IEB_OFF_MASK, 16'h0001);
      repeat (2) @(posedge clk_i);
      #1 check("irq raised", irq_o, 80'h1);
      wb(1'b1, `IEB_OFF_FLAG0, 16'h4000);
      wb(1'b0, `IEB_OFF_FLAG0, 16'h0000);
      check("flag read", rd[15:0], 80'h3FFF);
      wb(1'b0, `IEB_OFF_FLAG4, 16'h0000);
      check("flag 4 read", rd[15:0], 80'h00F6);
      wb(1'b0, `IEB_OFF_PEND, 16'h0000);
      check("pending", rd[4:0], 80'h1);
      check("flag cleared", req_o, 80'h0010);
      check("irq held", irq_o, 80'h1);
      wb(1'b1, `IEB_OFF_EN0, 16'h0000);
      wb(1'b0, `IEB_OFF_PEND, 16'h0000);
      check("pending off", rd[4:0], 80'h0);
      check("irq off", irq_o, 80'h0);
      $display("t_gate done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_gate();
      wrap_up();
   end
endmodule // tb_interrupt_enable_bank
